/* File: src/soc_pkg.sv */
// shared constants and types of the servo offset calibration block
package soc_pkg;
  // ****************************************************
  // widths and timing
  // ****************************************************
  localparam int SOC_DW = 10;
  localparam int SOC_CLK_HZ = 40_000_000;
  localparam int SOC_CLK_NS = 25;
  localparam int SOC_SAMPLE_HZ = 88_200;
  localparam int SOC_SAMPLE_CYC =
    (SOC_CLK_HZ + SOC_SAMPLE_HZ - 1) / SOC_SAMPLE_HZ;
  localparam int SOC_MEAS_MIN_NS = 2_900_000;
  localparam int SOC_MEAS_MAX_NS = 5_800_000;
  localparam int SOC_MEAS_MIN_CYC =
    (SOC_MEAS_MIN_NS + SOC_CLK_NS - 1) / SOC_CLK_NS;
  localparam int SOC_MEAS_MAX_CYC = SOC_MEAS_MAX_NS / SOC_CLK_NS;
  localparam int SOC_AVG_SHIFT = 8;
  localparam logic [7:0] SOC_AVG_LAST = 8'hff;
  // ****************************************************
  // register map (byte addresses) and reset values
  // ****************************************************
  localparam logic [7:0] SOC_A_CMD = 8'h00;
  localparam logic [7:0] SOC_A_STATUS = 8'h04;
  localparam logic [7:0] SOC_A_AVG_VC = 8'h08;
  localparam logic [7:0] SOC_A_AVG_FE = 8'h0c;
  localparam logic [7:0] SOC_A_AVG_RF = 8'h10;
  localparam logic [7:0] SOC_A_AVG_TE = 8'h14;
  localparam logic [7:0] SOC_A_TRAV = 8'h18;
  localparam logic [23:0] SOC_CMD_RST = 24'h000000;
  localparam logic [15:0] SOC_CTL_RST = 16'h0000;
  // ****************************************************
  // command codes and bit positions
  // ****************************************************
  localparam logic [7:0] SOC_OP_MEAS = 8'h38;
  localparam logic [7:0] SOC_OP_CLK = 8'h3f;
  localparam logic [3:0] SOC_OP_FOCUS = 4'h0;
  localparam int SOC_SEARCH_BIT = 17;
  localparam int SOC_QUARTER_BIT = 13;
  localparam int SOC_HALF_BIT = 12;
  localparam int SOC_CENTER_MEAS_BIT = 15;
  localparam int SOC_FOCUS_CC_BIT = 14;
  localparam int SOC_FOCUS_MEAS_BIT = 13;
  localparam int SOC_RF_COMP_BIT = 12;
  localparam int SOC_RF_MEAS_BIT = 11;
  localparam int SOC_ZC_COMP_BIT = 10;
  localparam int SOC_BAL_MEAS_BIT = 5;
  localparam int SOC_TRACK_MEAS_BIT = 4;
  localparam int SOC_FOCUS_CA_BIT = 3;
  localparam int SOC_BAL_COMP_BIT = 2;
  localparam int SOC_TRACK_CA_BIT = 1;
  localparam int SOC_TRACK_CC_BIT = 0;
  localparam int SOC_TRAV_SHIFT = 4;
  // ****************************************************
  // types
  // ****************************************************
  typedef struct packed {
    logic [SOC_DW-1:0] vc;
    logic [SOC_DW-1:0] fe;
    logic [SOC_DW-1:0] rf;
    logic [SOC_DW-1:0] te;
    logic [SOC_DW-1:0] se;
  } soc_err_s;
  typedef struct packed {
    logic [SOC_DW+1:0] trk;
    logic [SOC_DW+1:0] fcs;
    logic [SOC_DW+1:0] zc;
    logic [SOC_DW+1:0] rf;
    logic [SOC_DW+1:0] sled;
  } soc_fix_s;
  typedef enum logic {SOC_IDLE, SOC_RUN} soc_meas_e;
endpackage

/* File: src/soc_servo_offset.sv */
// servo clock divider, average measurement and offset compensation
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module soc_servo_offset import soc_pkg::*; #(
  parameter int DW = SOC_DW,
  parameter int SAMPLE_CYC = SOC_SAMPLE_CYC,
  parameter int MEAS_MAX_CYC = SOC_MEAS_MAX_CYC,
  parameter int MEAS_MIN_CYC = SOC_MEAS_MIN_CYC,
  parameter logic [SOC_DW+1:0] FOK_LEVEL = 12'h040
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic ref_clock_in,
  input wire logic crystal_select_pin,
  output logic servo_master_clock,
  output logic monitor_output,
  // converted error samples, same clock domain
  input soc_err_s err_in,
  // corrected values toward the servo filters
  output soc_fix_s fix_out,
  output logic focus_ok,
  output logic focus_zero_cross
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  localparam int AW = DW + SOC_AVG_SHIFT;
  localparam int OW = DW + 2;

  // ****************************************************
  // register bus and command latch
  // ****************************************************
  logic [23:0] cmd_r;
  logic [15:0] ctl_r;
  logic quarter_divide_sel_r;
  logic half_divide_sel_r;
  logic wr_acc;
  logic rd_setup;
  logic hit;
  logic [31:0] rd_nxt;
  logic [31:0] prdata_r;
  logic [DW-1:0] avg_r [4];
  logic [DW-1:0] traverse_offset_reg_r;
  soc_meas_e meas_r;
  logic done_r;
  logic div4_w;

  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign pready = psel & penable;
  assign prdata = prdata_r;

  always_comb begin
    hit = 1'b1;
    rd_nxt = 32'h0;
    if (paddr == SOC_A_CMD) begin
      rd_nxt = {8'h00, cmd_r};
    end else if (paddr == SOC_A_STATUS) begin
      rd_nxt = {29'h0, div4_w, done_r, meas_r == SOC_RUN};
    end else if (paddr == SOC_A_AVG_VC) begin
      rd_nxt = 32'(avg_r[0]);
    end else if (paddr == SOC_A_AVG_FE) begin
      rd_nxt = 32'(avg_r[1]);
    end else if (paddr == SOC_A_AVG_RF) begin
      rd_nxt = 32'(avg_r[2]);
    end else if (paddr == SOC_A_AVG_TE) begin
      rd_nxt = 32'(avg_r[3]);
    end else if (paddr == SOC_A_TRAV) begin
      rd_nxt = 32'(traverse_offset_reg_r);
    end else begin
      hit = 1'b0;
    end
  end

  assign pslverr = pready & ~hit;

  // read data is captured in the setup cycle so it leaves a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0;
    end else if (rd_setup) begin
      prdata_r <= rd_nxt;
    end
  end

  // the whole command word stays latched for monitor selection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_r <= SOC_CMD_RST;
      ctl_r <= SOC_CTL_RST;
    end else if (wr_acc && paddr == SOC_A_CMD) begin
      cmd_r <= pwdata[23:0];
      if (pwdata[23:16] == SOC_OP_MEAS) begin
        ctl_r <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quarter_divide_sel_r <= 1'b0;
      half_divide_sel_r <= 1'b0;
    end else if (wr_acc && paddr == SOC_A_CMD &&
                 pwdata[23:16] == SOC_OP_CLK) begin
      quarter_divide_sel_r <= pwdata[SOC_QUARTER_BIT];
      half_divide_sel_r <= pwdata[SOC_HALF_BIT];
    end
  end

  logic meas_go;
  assign meas_go = wr_acc && paddr == SOC_A_CMD &&
    pwdata[23:16] == SOC_OP_MEAS &&
    (pwdata[SOC_CENTER_MEAS_BIT] | pwdata[SOC_FOCUS_MEAS_BIT] |
     pwdata[SOC_RF_MEAS_BIT] | pwdata[SOC_TRACK_MEAS_BIT]);

  // ****************************************************
  // master clock divider
  // ****************************************************
  logic [2:0] ref_sync_r;
  logic [1:0] xsel_sync_r;
  logic [1:0] div_cnt_r;
  logic ref_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_sync_r <= 3'h0;
      xsel_sync_r <= 2'h0;
    end else begin
      ref_sync_r <= {ref_sync_r[1:0], ref_clock_in};
      xsel_sync_r <= {xsel_sync_r[0], crystal_select_pin};
    end
  end

  // reference must stay well below clk/2 for edges to be seen
  assign ref_rise = ref_sync_r[1] & ~ref_sync_r[2];
  assign div4_w = quarter_divide_sel_r |
    (~half_divide_sel_r & xsel_sync_r[1]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_r <= 2'h0;
      servo_master_clock <= 1'b0;
    end else if (ref_rise) begin
      if (div4_w) begin
        div_cnt_r <= div_cnt_r + 2'h1;
        servo_master_clock <= div_cnt_r[0] ? ~servo_master_clock
                                           : servo_master_clock;
      end else begin
        div_cnt_r <= 2'h0;
        servo_master_clock <= ~servo_master_clock;
      end
    end
  end

  div_half_a: assert property (ref_rise && !div4_w |=>
    servo_master_clock != $past(servo_master_clock))
    else $error("divide by two missed a toggle");

  // ****************************************************
  // sample tick and average measurement
  // ****************************************************
  logic [15:0] tick_cnt_r;
  logic tick;
  logic [7:0] samp_cnt_r;
  logic [3:0] sel_r;
  logic [DW-1:0] samp_w [4];
  logic [AW-1:0] acc_r [4];

  assign samp_w[0] = err_in.vc;
  assign samp_w[1] = err_in.fe;
  assign samp_w[2] = err_in.rf;
  assign samp_w[3] = err_in.te;
  assign tick = tick_cnt_r == 16'(SAMPLE_CYC - 1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= 16'h0;
    end else begin
      tick_cnt_r <= tick ? 16'h0 : tick_cnt_r + 16'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meas_r <= SOC_IDLE;
      sel_r <= 4'h0;
      samp_cnt_r <= 8'h0;
      done_r <= 1'b0;
    end else begin
      case (meas_r)
        SOC_IDLE: begin
          if (meas_go) begin
            meas_r <= SOC_RUN;
            sel_r <= {pwdata[SOC_TRACK_MEAS_BIT], pwdata[SOC_RF_MEAS_BIT],
                      pwdata[SOC_FOCUS_MEAS_BIT],
                      pwdata[SOC_CENTER_MEAS_BIT]};
            samp_cnt_r <= 8'h0;
            done_r <= 1'b0;
          end
        end
        SOC_RUN: begin
          // a measure command during a run starts no second run; ctl_r still takes its bits
          if (tick) begin
            samp_cnt_r <= samp_cnt_r + 8'h1;
            if (samp_cnt_r == SOC_AVG_LAST) begin
              meas_r <= SOC_IDLE;
              done_r <= 1'b1;
            end
          end
        end
        default: meas_r <= SOC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        acc_r[i] <= '0;
      end
    end else if (meas_r == SOC_IDLE) begin
      for (int i = 0; i < 4; i++) begin
        acc_r[i] <= '0;
      end
    end else if (tick) begin
      for (int i = 0; i < 4; i++) begin
        acc_r[i] <= acc_r[i] +
          AW'($signed(samp_w[i]));
      end
    end
  end

  // only the selected inputs update; the rest keep their value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        avg_r[i] <= '0;
      end
    end else if (meas_r == SOC_RUN && tick &&
                 samp_cnt_r == SOC_AVG_LAST) begin
      for (int i = 0; i < 4; i++) begin
        if (sel_r[i]) begin
          avg_r[i] <= DW'((acc_r[i] + AW'($signed(samp_w[i])))
                          >>> SOC_AVG_SHIFT);
        end
      end
    end
  end

  logic [17:0] run_cyc_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_cyc_r <= 18'h0;
    end else begin
      run_cyc_r <= (meas_r == SOC_RUN) ? run_cyc_r + 18'h1 : 18'h0;
    end
  end

  meas_max_a: assert property (run_cyc_r < 18'(MEAS_MAX_CYC))
    else $error("measurement ran past its longest time");
  meas_min_a: assert property (meas_r == SOC_RUN ##1
    meas_r == SOC_IDLE |-> $past(run_cyc_r) >= 18'(MEAS_MIN_CYC - 2))
    else $error("measurement ended too early");
  meas_start_a: assert property (meas_r == SOC_IDLE && meas_go |=>
    meas_r == SOC_RUN && samp_cnt_r == 8'h0)
    else $error("measure command did not start a run");
  avg_hold_a: assert property (!(meas_r == SOC_RUN && tick) |=>
    avg_r[1] == $past(avg_r[1]))
    else $error("average changed without a finished measurement");

  // ****************************************************
  // monitor pin
  // ****************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      monitor_output <= 1'b0;
    end else if (cmd_r[23:16] == SOC_OP_MEAS) begin
      monitor_output <= done_r;
    end else if (cmd_r[23:20] == SOC_OP_FOCUS &&
                 cmd_r[SOC_SEARCH_BIT]) begin
      monitor_output <= focus_zero_cross;
    end else begin
      monitor_output <= 1'b0;
    end
  end

  sequence run_ends_s;
    meas_r == SOC_RUN ##1 meas_r == SOC_IDLE;
  endsequence
  mon_done_a: assert property (run_ends_s ##0
    cmd_r[23:16] == SOC_OP_MEAS [*2] |=> monitor_output)
    else $error("completion not shown on monitor");

  // ****************************************************
  // balance offset
  // ****************************************************
  logic signed [DW-1:0] te_s;
  logic signed [DW-1:0] trav_s;
  assign te_s = $signed(err_in.te);
  assign trav_s = $signed(traverse_offset_reg_r);

  // one-pole low pass; a coarse shift trades ripple for settle time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      traverse_offset_reg_r <= '0;
    end else if (ctl_r[SOC_BAL_MEAS_BIT] && tick) begin
      traverse_offset_reg_r <= DW'(trav_s +
        ((te_s - trav_s) >>> SOC_TRAV_SHIFT));
    end
  end

  trav_freeze_a: assert property (!ctl_r[SOC_BAL_MEAS_BIT] |=>
    $stable(traverse_offset_reg_r))
    else $error("traverse offset moved while frozen");

  // ****************************************************
  // compensation
  // ****************************************************
  logic signed [OW-1:0] fe_x, rf_x, te_x, se_x, tr_x;
  logic signed [OW-1:0] av_vc, av_fe, av_rf, av_te;
  logic signed [OW-1:0] trk_w, fcs_w, zc_w, rf_w, sled_w;

  assign fe_x = OW'($signed(err_in.fe));
  assign rf_x = OW'($signed(err_in.rf));
  assign te_x = OW'($signed(err_in.te));
  assign se_x = OW'($signed(err_in.se));
  assign tr_x = OW'(trav_s);
  assign av_vc = OW'($signed(avg_r[0]));
  assign av_fe = OW'($signed(avg_r[1]));
  assign av_rf = OW'($signed(avg_r[2]));
  assign av_te = OW'($signed(avg_r[3]));

  always_comb begin
    trk_w = te_x;
    if (ctl_r[SOC_TRACK_CC_BIT]) begin
      trk_w = te_x - av_vc;
    end else if (ctl_r[SOC_TRACK_CA_BIT]) begin
      trk_w = te_x - av_te;
    end
    sled_w = se_x;
    if (ctl_r[SOC_BAL_COMP_BIT]) begin
      trk_w = trk_w - tr_x;
      sled_w = se_x - tr_x;
    end
    fcs_w = fe_x;
    if (ctl_r[SOC_FOCUS_CC_BIT]) begin
      fcs_w = fe_x - av_vc;
    end else if (ctl_r[SOC_FOCUS_CA_BIT]) begin
      fcs_w = fe_x - av_fe;
    end
    zc_w = ctl_r[SOC_ZC_COMP_BIT] ? fe_x - av_fe : fe_x;
    rf_w = ctl_r[SOC_RF_COMP_BIT] ? rf_x - av_rf : rf_x;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fix_out <= '0;
      focus_ok <= 1'b0;
      focus_zero_cross <= 1'b0;
    end else begin
      fix_out <= {trk_w, fcs_w, zc_w, rf_w, sled_w};
      focus_ok <= rf_w > $signed(FOK_LEVEL);
      focus_zero_cross <= zc_w > 0;
    end
  end

  rf_comp_a: assert property (ctl_r[SOC_RF_COMP_BIT] |=>
    $signed(fix_out.rf) == $past(rf_x) - $past(av_rf))
    else $error("rf level not reduced by its average");
  trk_center_a: assert property (ctl_r[SOC_TRACK_CC_BIT] &&
    !ctl_r[SOC_BAL_COMP_BIT] |=>
    $signed(fix_out.trk) == $past(te_x) - $past(av_vc))
    else $error("tracking not referenced to centre average");
  fcs_avg_a: assert property (ctl_r[SOC_FOCUS_CA_BIT] &&
    !ctl_r[SOC_FOCUS_CC_BIT] |=>
    $signed(fix_out.fcs) == $past(fe_x) - $past(av_fe))
    else $error("focus not referenced to its average");
  sled_bal_a: assert property (ctl_r[SOC_BAL_COMP_BIT] |=>
    $signed(fix_out.sled) == $past(se_x) - $past(tr_x))
    else $error("sled not reduced by traverse offset");
endmodule

/* File: testbench/soc_front_model.sv */
// analog front end model: reference clock and converted error levels
`timescale 1ns/100ps
module soc_front_model import soc_pkg::*; (
  // clock
  input wire logic clk,
  // levels requested by the bench
  input wire soc_err_s lv,
  // toward the block
  output logic ref_clock_in,
  output soc_err_s err_in
);
  // ****************************************************
  // reference clock
  // ****************************************************
  // period of 8 system clocks, so /2 gives 16 and /4 gives 32
  // odd start offset keeps the phase unrelated to clk
  initial begin
    ref_clock_in = 1'b0;
    #3;
    forever #100 ref_clock_in = ~ref_clock_in;
  end
  // ****************************************************
  // sampled levels
  // ****************************************************
  // quiet levels: exact averages, a noisy front end would need tolerance
  initial err_in = '0;
  always @(posedge clk) begin
    err_in <= lv;
  end
endmodule

/* File: testbench/soc_servo_offset_bench.sv */
// self-checking bench of the servo offset calibration block
`timescale 1ns/100ps
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin errors++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, x); end end
module soc_servo_offset_bench import soc_pkg::*;;
  // ****************************************************
  // settings and signals
  // ****************************************************
  // shortened counts: 256 ticks of 4 clocks per run
  localparam int MMIN = 1000;
  localparam int MMAX = 1100;
  localparam int VC0 = 16, FE0 = -16, RF0 = 32, RF1 = 48, TE0 = 8;
  localparam int VC1 = 80, FE1 = 100, RF2 = 192, TE1 = 200, SE1 = 10;
  localparam int TB = 32, TE2 = 256, FE2 = -32, RF3 = 80;
  localparam logic [31:0] DCMD [4] = '{32'h003f0000, 32'h003f1000,
    32'h003f2000, 32'h003f0000};
  localparam logic DXS [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  localparam logic DX4 [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  localparam int MBIT [4] = '{15, 13, 11, 4};
  localparam logic [7:0] MADR [4] = '{SOC_A_AVG_VC, SOC_A_AVG_FE,
    SOC_A_AVG_RF, SOC_A_AVG_TE};
  localparam int MVAL [4] = '{VC0, FE0, RF0, TE0};
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic ref_clock_in, crystal_select_pin, servo_master_clock;
  logic monitor_output, focus_ok, focus_zero_cross;
  soc_err_s lv, err_in;
  soc_fix_s fix_out;
  int errors, num_checks;
  // ****************************************************
  // instances
  // ****************************************************
  soc_servo_offset #(.SAMPLE_CYC(4), .MEAS_MAX_CYC(MMAX),
    .MEAS_MIN_CYC(MMIN)) i_dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_clock_in(ref_clock_in), .crystal_select_pin(crystal_select_pin),
    .servo_master_clock(servo_master_clock),
    .monitor_output(monitor_output), .err_in(err_in), .fix_out(fix_out),
    .focus_ok(focus_ok), .focus_zero_cross(focus_zero_cross));
  soc_front_model i_front (.clk(clk), .lv(lv), .ref_clock_in(ref_clock_in),
    .err_in(err_in));
  // ****************************************************
  // tasks
  // ****************************************************
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // outputs are looked at 1 ns after the edge, once its updates landed
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errors++;
      $display("unexpected at %0t: no ready", $time);
      results();
    end
  endtask
  // waits on the monitor pin instead of a blind 5.8 ms gap
  task automatic meas(input logic [31:0] cmd);
    logic [31:0] q;
    logic e;
    int n;
    apb(1'b1, SOC_A_CMD, cmd, q, e);
    apb(1'b0, SOC_A_STATUS, '0, q, e);
    `CHK(q[1:0], 2'h1)
    n = 0;
    while (monitor_output !== 1'b1 && n < MMAX) begin
      tick(1);
      n++;
    end
    if (n >= MMAX) begin
      errors++;
      $display("unexpected at %0t: no completion", $time);
      results();
    end
    `CHK(n + 4 >= MMIN && n <= MMAX, 1'b1)
  endtask
  // ****************************************************
  // stimulus
  // ****************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    logic [31:0] q;
    logic e, p;
    int c;
    errors = 0;
    num_checks = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    crystal_select_pin = 1'b0;
    lv = '{vc: 10'(VC0), fe: 10'(FE0), rf: 10'(RF0), te: 10'(TE0),
      se: 10'(SE1)};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, SOC_A_CMD, '0, q, e);
    `CHK(q, 32'h00000000)
    apb(1'b0, SOC_A_STATUS, '0, q, e);
    `CHK(q, 32'h00000000)
    apb(1'b0, 8'h40, '0, q, e);
    `CHK({e, q}, 33'h100000000)
    apb(1'b1, 8'h40, 32'h00ffffff, q, e);
    `CHK(e, 1'b1)
    $display("test reset and map done");
    for (int i = 0; i < 4; i++) begin
      crystal_select_pin <= DXS[i];
      apb(1'b1, SOC_A_CMD, DCMD[i], q, e);
      tick(20);
      apb(1'b0, SOC_A_STATUS, '0, q, e);
      `CHK(q[2], DX4[i])
      c = 0;
      p = servo_master_clock;
      repeat (320) begin
        tick(1);
        if (servo_master_clock && !p) c++;
        p = servo_master_clock;
      end
      `CHK(c >= (DX4[i] ? 9 : 19) && c <= (DX4[i] ? 11 : 21), 1'b1)
    end
    $display("test divider done");
    // one input at a time, each finished before the next
    for (int i = 0; i < 4; i++) begin
      meas(32'h00380000 | (32'h1 << MBIT[i]));
      apb(1'b0, MADR[i], '0, q, e);
      `CHK(q[9:0], 10'(MVAL[i]))
    end
    apb(1'b0, SOC_A_STATUS, '0, q, e);
    `CHK(q[1:0], 2'h2)
    lv.vc <= 10'(VC1);
    lv.rf <= 10'(RF1);
    meas(32'h00380800);
    apb(1'b0, SOC_A_AVG_RF, '0, q, e);
    `CHK(q[9:0], 10'(RF1))
    apb(1'b0, SOC_A_AVG_VC, '0, q, e);
    `CHK(q[9:0], 10'(VC0))
    apb(1'b1, SOC_A_CMD, 32'h003f0000, q, e);
    tick(3);
    `CHK(monitor_output, 1'b0)
    $display("test measurement done");
    lv.fe <= 10'(FE1);
    lv.rf <= 10'(RF2);
    lv.te <= 10'(TE1);
    // all wanted compensations enabled in one command
    apb(1'b1, SOC_A_CMD, 32'h00385401, q, e);
    tick(4);
    `CHK(fix_out.trk, 12'(TE1 - VC0))
    `CHK(fix_out.fcs, 12'(FE1 - VC0))
    `CHK(fix_out.zc, 12'(FE1 - FE0))
    `CHK(fix_out.rf, 12'(RF2 - RF1))
    `CHK({focus_ok, focus_zero_cross}, 2'h3)
    apb(1'b1, SOC_A_CMD, 32'h00020000, q, e);
    tick(3);
    `CHK(monitor_output, 1'b1)
    lv.fe <= 10'(FE2);
    lv.rf <= 10'(RF3);
    tick(4);
    `CHK(fix_out.zc, 12'(FE2 - FE0))
    `CHK({focus_ok, monitor_output}, 2'h0)
    lv.fe <= 10'(FE1);
    apb(1'b1, SOC_A_CMD, 32'h0038000a, q, e);
    tick(4);
    `CHK(fix_out.trk, 12'(TE1 - TE0))
    `CHK(fix_out.fcs, 12'(FE1 - FE0))
    $display("test compensation done");
    // the low-pass stops once the gap is under 16, so it settles at TB-15
    lv.te <= 10'(TB);
    apb(1'b1, SOC_A_CMD, 32'h00380020, q, e);
    tick(1000);
    apb(1'b0, SOC_A_TRAV, '0, q, e);
    `CHK(q[9:0], 10'(TB - 15))
    apb(1'b1, SOC_A_CMD, 32'h00380000, q, e);
    lv.te <= 10'(TE2);
    tick(200);
    apb(1'b0, SOC_A_TRAV, '0, q, e);
    `CHK(q[9:0], 10'(TB - 15))
    apb(1'b1, SOC_A_CMD, 32'h00380004, q, e);
    tick(4);
    `CHK(fix_out.trk, 12'(TE2 - TB + 15))
    `CHK(fix_out.sled, 12'(SE1 - TB + 15))
    $display("test balance done");
    results();
  end
endmodule
